// ### logic/ppm_pkg.sv
// Purpose: shared constants and carriers for the port pin function mux
// Assumes: 50 MHz clock, oscillator equals the system clock
// Notes: one machine cycle is six clocks, three in double-speed mode
package ppm_pkg;
	// =====================================================
	// timing
	localparam int unsigned CLK_HZ = 50000000;
	localparam logic [2:0] CYCLE_NORMAL = 3'h6;
	localparam logic [2:0] CYCLE_DOUBLE = 3'h3;
	localparam logic [2:0] PULLUP_BOOST_CLKS = 3'h2;
	localparam logic [3:0] RESET_MACHINE_CYCLES = 4'h2;
	localparam logic [7:0] LATCH_RESET = 8'hff;
	// =====================================================
	// auxiliary control bit positions
	localparam int ALE_OFF_BIT = 0;
	localparam int PULLUP_DIS_BIT = 7;
	// =====================================================
	// carriers
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} ppm_pins_type;

	typedef struct packed {
		logic active;      // external access in progress
		logic is_data;     // data access (not a fetch)
		logic wide;        // 16-bit address data access
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic drive_data;  // port zero drives write data
	} ppm_xbus_type;

	typedef struct packed {
		logic master;
		logic enable;
		logic sck;
		logic mosi;
		logic miso;
	} ppm_spi_type;

	typedef struct packed {
		logic [4:0] cex_out;
		logic [4:0] cex_oe;
		logic t2_clkout;
		logic t2_clkout_en;
		logic txd;
	} ppm_periph_type;

	typedef enum logic [2:0] {
		PPM_NORMAL = 3'b001,
		PPM_PROGRAM = 3'b010,
		PPM_VERIFY = 3'b100
	} ppm_mode_type;
endpackage

// ### logic/ppm_port_mux.sv
// Purpose: pin level logic of four 8-bit ports with alternate functions
// Assumes: pins are split into input, output and output enable
// Notes: pin drive strength shown as separate strong/weak enable vectors
`timescale 1ns/1ps

module ppm_port_mux #(
	parameter int FLASH_ADDR_BITS = 7
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// port latches and control
	input wire logic [7:0] i_p0_latch,
	input wire logic [7:0] i_p1_latch,
	input wire logic [7:0] i_port_two_latch,
	input wire logic [7:0] i_p3_latch,
	input wire logic [7:0] i_auxiliary_control_register,
	input wire logic i_double_speed_mode,
	input wire logic i_internal_fetch,
	input wire ppm_pkg::ppm_mode_type i_mode,
	input wire logic i_watchdog_reset,
	input wire logic [7:0] i_verify_code,
	// cpu external bus and peripherals
	input wire ppm_pkg::ppm_xbus_type i_xbus,
	input wire ppm_pkg::ppm_spi_type i_spi,
	input wire ppm_pkg::ppm_periph_type i_periph,
	// pins
	input wire logic [7:0] i_p0_pin,
	input wire logic [7:0] i_p1_pin,
	input wire logic [7:0] i_p2_pin,
	input wire logic [7:0] i_p3_pin,
	input wire logic i_rst_pin,
	input wire logic i_ale_pin,
	output ppm_pkg::ppm_pins_type o_p0,
	output ppm_pkg::ppm_pins_type o_p1,
	output ppm_pkg::ppm_pins_type o_p2,
	output ppm_pkg::ppm_pins_type o_p3,
	output logic [23:0] o_weak_pullup,
	output logic o_rst_pin_out,
	output logic o_rst_pin_oe,
	output logic o_ale_out,
	output logic o_ale_oe,
	// synchronised pin values toward core
	output logic [7:0] o_p0_in,
	output logic [7:0] o_p1_in,
	output logic [7:0] o_p2_in,
	output logic [7:0] o_p3_in,
	output logic o_rxd,
	output logic o_external_interrupt_zero,
	output logic o_external_interrupt_one,
	output logic o_timer_zero_count_input,
	output logic o_timer_one_count_input,
	output logic o_timer2_count_clockout_pin,
	output logic o_timer2_reload_capture_pin,
	output logic o_spi_slave_select_n,
	output logic o_counter_array_external_clock,
	output logic [4:0] o_counter_array_module_io,
	output logic o_spi_miso_in,
	output logic o_spi_mosi_in,
	output logic o_spi_sck_in,
	output logic o_program_pulse_input,
	output logic [15:0] o_flash_addr,
	output logic [7:0] o_flash_data,
	output logic o_pin_reset
);
	// =====================================================
	// input synchronisers
	logic [33:0] sync1_q;
	logic [33:0] sync2_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_ale_pin, i_rst_pin, i_p3_pin, i_p2_pin, i_p1_pin, i_p0_pin};
			sync2_q <= sync1_q;
		end
	end
	logic [7:0] p0_s, p1_s, p2_s, p3_s;
	logic rst_s, ale_s;
	assign {ale_s, rst_s, p3_s, p2_s, p1_s, p0_s} = sync2_q;
	assign o_p0_in = p0_s;
	assign o_p1_in = p1_s;
	assign o_p2_in = p2_s;
	assign o_p3_in = p3_s;

	// =====================================================
	// machine cycle divider
	logic [2:0] div_q;
	logic [2:0] cycle_len;
	logic mc_tick;
	assign cycle_len = i_double_speed_mode ? ppm_pkg::CYCLE_DOUBLE : ppm_pkg::CYCLE_NORMAL;
	assign mc_tick = (div_q >= cycle_len - 3'h1);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= mc_tick ? 3'h0 : div_q + 3'h1;
		end
	end

	// =====================================================
	// address latch strobe
	logic data_seen_q;
	logic skip_q;
	logic ale_q;
	logic ale_blank;
	logic programming;
	assign programming = (i_mode != ppm_pkg::PPM_NORMAL);
	assign ale_blank = i_auxiliary_control_register[ppm_pkg::ALE_OFF_BIT] && i_internal_fetch;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_seen_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			data_seen_q <= i_xbus.active && i_xbus.is_data;
			// one pulse skipped at the start of each data access
			if (mc_tick) begin
				skip_q <= 1'b0;
			end
			if (i_xbus.active && i_xbus.is_data && !data_seen_q) begin
				skip_q <= 1'b1;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ale_q <= 1'b0;
		end else begin
			ale_q <= mc_tick && !skip_q && !ale_blank;
		end
	end
	assign o_ale_out = ale_q;
	assign o_ale_oe = !programming;
	assign o_program_pulse_input = programming && ale_s;

	// =====================================================
	// reset pin
	logic [3:0] rst_cnt_q;
	logic pin_reset_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_cnt_q <= '0;
			pin_reset_q <= 1'b0;
		end else if (!rst_s || o_rst_pin_oe) begin
			rst_cnt_q <= '0;
			pin_reset_q <= 1'b0;
		end else if (mc_tick && rst_cnt_q < ppm_pkg::RESET_MACHINE_CYCLES) begin
			rst_cnt_q <= rst_cnt_q + 4'h1;
		end else if (rst_cnt_q >= ppm_pkg::RESET_MACHINE_CYCLES) begin
			pin_reset_q <= 1'b1;
		end
	end
	assign o_pin_reset = pin_reset_q;
	assign o_rst_pin_oe = i_watchdog_reset;
	assign o_rst_pin_out = i_watchdog_reset;

	// =====================================================
	// strong pull-up boost on latch rise
	logic [23:0] latch_prev_q;
	logic [23:0] boost_q [0:1];
	logic [23:0] latches;
	assign latches = {i_p3_latch, i_port_two_latch, i_p1_latch};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_prev_q <= {3{ppm_pkg::LATCH_RESET}};
			boost_q[0] <= '0;
			boost_q[1] <= '0;
		end else begin
			latch_prev_q <= latches;
			boost_q[0] <= latches & ~latch_prev_q;
			boost_q[1] <= boost_q[0];
		end
	end
	logic [23:0] boost;
	assign boost = boost_q[0] | boost_q[1];
	// weak pull-up on ones always; on zeros unless disabled
	assign o_weak_pullup = latches |
		{24{!i_auxiliary_control_register[ppm_pkg::PULLUP_DIS_BIT]}};

	// =====================================================
	// port zero
	always_comb begin
		o_p0.out = '0;
		o_p0.oe = ~i_p0_latch;
		if (i_mode == ppm_pkg::PPM_PROGRAM) begin
			o_p0.oe = '0;
		end else if (i_mode == ppm_pkg::PPM_VERIFY) begin
			o_p0.out = '0;
			o_p0.oe = ~i_verify_code;
		end else if (i_xbus.active) begin
			o_p0.out = i_xbus.drive_data ? i_xbus.wdata : i_xbus.addr[7:0];
			o_p0.oe = (i_xbus.drive_data || !i_xbus.rd) ? 8'hff : 8'h00;
		end
	end

	// =====================================================
	// port two
	logic p2_addr;
	assign p2_addr = i_xbus.active && (!i_xbus.is_data || i_xbus.wide);
	always_comb begin
		if (programming) begin
			o_p2.out = '0;
			o_p2.oe = '0;
		end else if (p2_addr) begin
			o_p2.out = i_xbus.addr[15:8];
			o_p2.oe = 8'hff;
		end else begin
			o_p2.out = i_port_two_latch;
			o_p2.oe = ~i_port_two_latch | boost[15:8];
		end
	end
	assign o_flash_addr = {{(8-FLASH_ADDR_BITS){1'b0}}, p2_s[FLASH_ADDR_BITS-1:0], p1_s};
	assign o_flash_data = p0_s;

	// =====================================================
	// port one
	logic [7:0] p1_alt_out, p1_alt_en;
	always_comb begin
		p1_alt_out = '0;
		p1_alt_en = '0;
		p1_alt_out[0] = i_periph.t2_clkout;
		p1_alt_en[0] = i_periph.t2_clkout_en;
		p1_alt_out[7:3] = i_periph.cex_out;
		p1_alt_en[7:3] = i_periph.cex_oe;
		if (i_spi.enable && i_spi.master) begin
			p1_alt_out[6] = i_spi.sck;
			p1_alt_en[6] = 1'b1;
			p1_alt_out[7] = i_spi.mosi;
			p1_alt_en[7] = 1'b1;
			p1_alt_en[5] = 1'b0;
		end else if (i_spi.enable) begin
			p1_alt_out[5] = i_spi.miso;
			p1_alt_en[5] = 1'b1;
			p1_alt_en[7:6] = 2'h0;
		end
	end
	always_comb begin
		o_p1.out = '0;
		o_p1.oe = '0;
		if (!programming) begin
			for (int b = 0; b < 8; b++) begin
				o_p1.out[b] = p1_alt_en[b] ? p1_alt_out[b] : i_p1_latch[b];
				o_p1.oe[b] = p1_alt_en[b] | ~i_p1_latch[b] | boost[b];
			end
		end
	end
	assign o_timer2_count_clockout_pin = p1_s[0];
	assign o_timer2_reload_capture_pin = p1_s[1];
	assign o_spi_slave_select_n = p1_s[1];
	assign o_counter_array_external_clock = p1_s[2];
	assign o_counter_array_module_io = p1_s[7:3];
	assign o_spi_miso_in = p1_s[5];
	assign o_spi_mosi_in = p1_s[7];
	assign o_spi_sck_in = p1_s[6];

	// =====================================================
	// port three
	logic [7:0] p3_alt_out, p3_alt_en;
	always_comb begin
		p3_alt_out = 8'hff;
		p3_alt_en = '0;
		p3_alt_out[1] = i_periph.txd;
		p3_alt_en[1] = !i_p3_latch[1] ? 1'b0 : 1'b1;
		if (i_xbus.active && i_xbus.is_data) begin
			p3_alt_out[6] = !i_xbus.wr;
			p3_alt_out[7] = !i_xbus.rd;
			p3_alt_en[7:6] = 2'h3;
		end
	end
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			o_p3.out[b] = p3_alt_en[b] ? p3_alt_out[b] : i_p3_latch[b];
			o_p3.oe[b] = p3_alt_en[b] | ~i_p3_latch[b] | boost[16+b];
		end
	end
	assign o_rxd = p3_s[0];
	assign o_external_interrupt_zero = p3_s[2];
	assign o_external_interrupt_one = p3_s[3];
	assign o_timer_zero_count_input = p3_s[4];
	assign o_timer_one_count_input = p3_s[5];

	// =====================================================
	// checks
	ale_rate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_ale_out |-> $past(mc_tick)) else $error("strobe not on cycle edge");
	ale_blank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(ale_blank) |-> !o_ale_out) else $error("strobe during internal fetch");
	ale_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_xbus.active && i_xbus.is_data && !data_seen_q && !mc_tick) ##1 mc_tick
		|=> !o_ale_out) else $error("strobe not skipped");
	p0_float_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_xbus.active && !programming) |-> (o_p0.oe == ~i_p0_latch))
		else $error("port zero drives a one");
	p2_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(p2_addr && !programming) |-> (o_p2.out == i_xbus.addr[15:8] && &o_p2.oe))
		else $error("port two address wrong");
	boost_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_p1_latch[0]) ##1 $stable(i_p1_latch[0]) |-> boost[0] ##1 boost[0] ##1 !boost[0])
		else $error("boost length wrong");
	rst_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_watchdog_reset |-> (o_rst_pin_oe && o_rst_pin_out)) else $error("reset pin not driven");
	spi_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_spi.enable && i_spi.master && !programming) |-> (o_p1.out[6] == i_spi.sck && o_p1.oe[6]))
		else $error("spi master pins wrong");
	program_pulse_input_ale_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		programming |-> !o_ale_oe) else $error("strobe driven while programming");
	pin_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!rst_s |=> !o_pin_reset) else $error("reset held without pin");
	p2_narrow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_xbus.active && i_xbus.is_data && !i_xbus.wide && !programming)
		|-> (o_p2.out == i_port_two_latch)) else $error("port two narrow access wrong");
	p3_strobe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_xbus.active && i_xbus.is_data)
		|-> (o_p3.out[7:6] == {!i_xbus.rd, !i_xbus.wr} && &o_p3.oe[7:6]))
		else $error("data strobes wrong");
	p0_verify_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_mode == ppm_pkg::PPM_VERIFY) |-> (o_p0.oe == ~i_verify_code && o_p0.out == 8'h00))
		else $error("code byte not shown");
	ext_data_c: cover property (@(posedge i_clk) i_xbus.active && i_xbus.is_data && i_xbus.wide);
	spi_slave_c: cover property (@(posedge i_clk) i_spi.enable && !i_spi.master);
	pin_reset_c: cover property (@(posedge i_clk) $rose(o_pin_reset));
	program_pulse_input_mode_c: cover property (@(posedge i_clk) programming && o_program_pulse_input);
	fast_strobe_c: cover property (@(posedge i_clk) i_double_speed_mode && o_ale_out);
endmodule // ppm_port_mux

// ### sim/port_pin_function_mux_test.sv
// Purpose: self-checking bench for the port pin function mux
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes: strobe counts taken over whole multiples of the machine cycle
`timescale 1ns/1ps

module port_pin_function_mux_test;
	logic i_clk = 0;
	logic i_rst_n = 0;
	logic [7:0] p0l = 8'hff, p1l = 8'hff, p2l = 8'hff, p3l = 8'hff, aux = 8'h00;
	logic dbl = 0, ifetch = 0, wdog = 0, hold = 0;
	logic [7:0] ext = 8'hff;
	ppm_pkg::ppm_mode_type mode = ppm_pkg::PPM_NORMAL;
	ppm_pkg::ppm_xbus_type xb = '0;
	ppm_pkg::ppm_spi_type spi = '0;
	ppm_pkg::ppm_periph_type per = '0;
	ppm_pkg::ppm_pins_type p0, p1, p2, p3;
	logic [7:0] p0p, p1p, p2p, p3p;
	logic [23:0] wpu;
	logic rst_o, rst_oe, ale_o, ale_oe, rst_p, ale_p, rxd, pin_rst;
	logic program_pulse_input = 0, pp;
	logic [7:0] vcode = 8'h00, p0i, p1i, p2i, p3i, fd;
	logic [15:0] fa;
	wire logic [15:0] alt_in;
	int miscompares = 0, n_checks = 0, cyc = 0;

	always #10 i_clk = ~i_clk;

	ppm_port_mux DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_p0_latch(p0l), .i_p1_latch(p1l),
		.i_port_two_latch(p2l), .i_p3_latch(p3l), .i_auxiliary_control_register(aux),
		.i_double_speed_mode(dbl), .i_internal_fetch(ifetch), .i_mode(mode),
		.i_watchdog_reset(wdog), .i_verify_code(vcode), .i_xbus(xb), .i_spi(spi),
		.i_periph(per), .i_p0_pin(p0p), .i_p1_pin(p1p), .i_p2_pin(p2p), .i_p3_pin(p3p),
		.i_rst_pin(rst_p), .i_ale_pin(ale_p), .o_p0(p0), .o_p1(p1), .o_p2(p2), .o_p3(p3),
		.o_weak_pullup(wpu), .o_rst_pin_out(rst_o), .o_rst_pin_oe(rst_oe),
		.o_ale_out(ale_o), .o_ale_oe(ale_oe), .o_p0_in(p0i), .o_p1_in(p1i), .o_p2_in(p2i),
		.o_p3_in(p3i), .o_rxd(rxd), .o_external_interrupt_zero(alt_in[15]),
		.o_external_interrupt_one(alt_in[14]), .o_timer_zero_count_input(alt_in[13]),
		.o_timer_one_count_input(alt_in[12]), .o_timer2_count_clockout_pin(alt_in[11]),
		.o_timer2_reload_capture_pin(alt_in[10]), .o_spi_slave_select_n(alt_in[9]),
		.o_counter_array_external_clock(alt_in[8]), .o_counter_array_module_io(alt_in[7:3]),
		.o_spi_miso_in(alt_in[2]), .o_spi_mosi_in(alt_in[1]), .o_spi_sck_in(alt_in[0]),
		.o_program_pulse_input(pp), .o_flash_addr(fa), .o_flash_data(fd), .o_pin_reset(pin_rst));

	ppm_board board (.i_p0(p0), .i_p1(p1), .i_p2(p2), .i_p3(p3), .i_rst_out(rst_o),
		.i_rst_oe(rst_oe), .i_ale_out(ale_o), .i_ale_oe(ale_oe), .i_ext(ext),
		.i_rst_hold(hold), .i_program_pulse_input(program_pulse_input), .o_p0_pin(p0p), .o_p1_pin(p1p), .o_p2_pin(p2p),
		.o_p3_pin(p3p), .o_rst_pin(rst_p), .o_ale_pin(ale_p));

	// =====================================================
	// checking and closing
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic ale_count(input int len, input int exp);
		int n;
		n = 0;
		repeat (len) begin
			@(negedge i_clk);
			n += ale_o;
		end
		chk("strobe count", 16'(n), 16'(exp));
	endtask

	// =====================================================
	// scenarios
	task automatic t_port_zero();
		@(negedge i_clk);
		p0l = 8'hff;
		#1 chk("p0 oe on ones", 16'(p0.oe), 16'h0000);
		p0l = 8'h0f;
		#1 chk("p0 oe on zeros", 16'(p0.oe & ~p0.out), 16'h00f0);
		p0l = 8'hff;
	endtask

	task automatic t_ext_bus();
		@(negedge i_clk);
		xb = '{active: 1'b1, addr: 16'ha55a, default: '0};
		#1 chk("p2 high addr", {p2.oe, p2.out}, 16'hffa5);
		chk("p0 low addr", {p0.oe, p0.out}, 16'hff5a);
		p2l = 8'h3c;
		xb.is_data = 1'b1;
		ale_count(60, 9);
		chk("p2 narrow latch", 16'(p2.out), 16'h003c);
		chk("p3 strobes idle", {12'h000, p3.oe[7:6], p3.out[7:6]}, 16'h000f);
		xb.rd = 1'b1;
		#1 chk("p3 read strobe", {12'h000, p3.oe[7:6], p3.out[7:6]}, 16'h000d);
		chk("p0 released for read", 16'(p0.oe), 16'h0000);
		xb = '0;
		p2l = 8'hff;
	endtask

	task automatic t_strobe();
		ale_count(60, 10);
		dbl = 1'b1;
		repeat (6) @(negedge i_clk);
		ale_count(60, 20);
		dbl = 1'b0;
		aux = 8'h01;
		ifetch = 1'b1;
		repeat (6) @(negedge i_clk);
		ale_count(60, 0);
		aux = 8'h00;
		ifetch = 1'b0;
	endtask

	task automatic t_boost();
		int n;
		n = 0;
		p1l = 8'h0e;
		aux = 8'h80;
		#1 chk("weak pull-up off", 16'(wpu[7:0]), 16'h000e);
		aux = 8'h00;
		#1 chk("weak pull-up on", 16'(wpu[7:0]), 16'h00ff);
		p1l = 8'hfe;
		repeat (4) @(negedge i_clk);
		p1l = 8'hff;
		repeat (5) begin
			@(negedge i_clk);
			n += p1.oe[0];
		end
		chk("boost cycles", 16'(n), 16'(ppm_pkg::PULLUP_BOOST_CLKS));
	endtask

	task automatic t_spi();
		@(negedge i_clk);
		spi = '{master: 1'b1, enable: 1'b1, sck: 1'b1, mosi: 1'b0, miso: 1'b0};
		#1 chk("master p1", {p1.oe[7:5], p1.out[7:6]}, 16'h0019);
		spi.master = 1'b0;
		#1 chk("slave p1", {p1.oe[7], p1.oe[5], p1.out[5]}, 16'h0002);
		spi = '0;
	endtask

	task automatic t_inputs();
		@(negedge i_clk);
		ext = 8'ha5;
		repeat (3) @(negedge i_clk);
		chk("p1 p3 in", {p1i, p3i}, 16'ha5a5);
		chk("p0 p2 in", {p0i, p2i}, 16'hffa5);
		chk("alt inputs", alt_in, 16'h99a6);
		ext = 8'hff;
		per = '{cex_out: 5'h0a, cex_oe: 5'h1f, t2_clkout: 1'b0, t2_clkout_en: 1'b1, txd: 1'b1};
		#1 chk("p1 alt drive", {p1.oe, p1.out}, 16'hf956);
		chk("txd drive", {15'h0000, p3.out[1]}, 16'h0001);
		per = '0;
	endtask

	// released port zero reads high through the board pull-ups
	task automatic t_program();
		@(negedge i_clk);
		mode = ppm_pkg::PPM_PROGRAM;
		ext = 8'hda;
		program_pulse_input = 1'b1;
		#1 chk("program_pulse_input pins released", {p0.oe, p2.oe}, 16'h0000);
		chk("program_pulse_input strobe released", 16'(ale_oe), 16'h0000);
		repeat (3) @(negedge i_clk);
		chk("flash addr", fa, 16'h5ada);
		chk("flash data", 16'(fd), 16'h00ff);
		chk("program pulse", 16'(pp), 16'h0001);
		mode = ppm_pkg::PPM_VERIFY;
		vcode = 8'h3c;
		#1 chk("verify drive", {p0.oe, p0.out}, 16'hc300);
		chk("verify pins", 16'(p0p), 16'h003c);
		mode = ppm_pkg::PPM_NORMAL;
		ext = 8'hff;
		program_pulse_input = 1'b0;
	endtask

	task automatic t_reset_pin();
		@(negedge i_clk);
		ext = 8'hfe;
		hold = 1'b1;
		repeat (6) @(negedge i_clk);
		chk("rxd follows pin", 16'(rxd), 16'h0000);
		chk("pin reset early", 16'(pin_rst), 16'h0000);
		repeat (14) @(negedge i_clk);
		chk("pin reset late", 16'(pin_rst), 16'h0001);
		hold = 1'b0;
		ext = 8'hff;
		wdog = 1'b1;
		#1 chk("watchdog drive", {rst_oe, rst_o}, 16'h0003);
		wdog = 1'b0;
	endtask

	initial begin
		repeat (3) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_clk);
		t_port_zero();
		t_strobe();
		t_ext_bus();
		t_boost();
		t_spi();
		t_inputs();
		t_program();
		t_reset_pin();
		wrap_up();
	end
endmodule // port_pin_function_mux_test

// ### sim/ppm_board.sv
// Purpose: board around the port mux: pull-ups, outside drivers, reset pin
// Assumes: outside parties drive only pins the device leaves released
// Notes: port zero carries external pull-ups so released lines read high
`timescale 1ns/1ps

module ppm_board (
	// device side
	input wire ppm_pkg::ppm_pins_type i_p0,
	input wire ppm_pkg::ppm_pins_type i_p1,
	input wire ppm_pkg::ppm_pins_type i_p2,
	input wire ppm_pkg::ppm_pins_type i_p3,
	input wire logic i_rst_out,
	input wire logic i_rst_oe,
	input wire logic i_ale_out,
	input wire logic i_ale_oe,
	// outside drivers
	input wire logic [7:0] i_ext,
	input wire logic i_rst_hold,
	input wire logic i_program_pulse_input,
	// resolved pins
	output logic [7:0] o_p0_pin,
	output logic [7:0] o_p1_pin,
	output logic [7:0] o_p2_pin,
	output logic [7:0] o_p3_pin,
	output logic o_rst_pin,
	output logic o_ale_pin
);
	// =====================================================
	// resolution
	assign o_p0_pin = i_p0.oe & i_p0.out | ~i_p0.oe;
	assign o_p1_pin = i_p1.oe & i_p1.out | ~i_p1.oe & i_ext;
	assign o_p2_pin = i_p2.oe & i_p2.out | ~i_p2.oe & i_ext;
	assign o_p3_pin = i_p3.oe & i_p3.out | ~i_p3.oe & i_ext;
	// held by the testbench for the full count of machine cycles
	assign o_rst_pin = i_rst_oe ? i_rst_out : i_rst_hold;
	assign o_ale_pin = i_ale_oe ? i_ale_out : i_program_pulse_input;
endmodule // ppm_board
